// ===== rtl/distributed_dma_pkg.sv
// Purpose: Shared constants for the distributed DMA slave channel.
// Assumes: 32-bit PCI AD bus, byte lanes per PCI byte enables.
// Notes:   Offsets are byte offsets inside the 16-byte I/O window.
package distributed_dma_pkg;
  // ==========================================================
  // Window and configuration
  // ==========================================================
  localparam logic [7:0]  CFG_BASE_OFFSET = 8'h98;
  localparam int          WINDOW_BITS     = 4;
  localparam logic [31:0] WINDOW_MASK     = 32'hFFFF_FFF0;
  localparam logic [31:0] IO_SPACE_FLAG   = 32'h0000_0001;
  // Byte offsets inside the window
  localparam logic [3:0]  OFS_ADDR        = 4'h0;
  localparam logic [3:0]  OFS_COUNT       = 4'h4;
  localparam logic [3:0]  OFS_STATUS      = 4'h8;
  localparam logic [3:0]  OFS_MULTI       = 4'hC;
  // ==========================================================
  // Reset values and fields
  // ==========================================================
  localparam logic [15:0] ADDR_RESET      = 16'h0000;
  localparam logic [15:0] COUNT_RESET     = 16'h0000;
  localparam logic [7:0]  PAGE_RESET      = 8'h00;
  localparam logic [7:0]  BYTE_RESET      = 8'h00;
  localparam int          CMD_DISABLE_BIT = 2;
  localparam int          MASK_BIT        = 0;
  localparam logic [7:0]  MODE_WR_MASK    = 8'hFC;
  localparam logic [15:0] STEP_8BIT       = 16'h0001;
  localparam logic [15:0] STEP_16BIT      = 16'h0002;
endpackage : distributed_dma_pkg

// ===== rtl/addr_phase_if.sv
// Purpose: Carries channel address state to the address-phase formatter.
// Assumes: One clock domain.
// Notes:   ad_value is combinational; the top registers it.
`timescale 1ns/1ps
`default_nettype none
interface addr_phase_if;
  logic [15:0] cur_addr;
  logic [7:0]  page;
  logic        wide_mode;
  logic [31:0] ad_value;
  modport channel (output cur_addr, output page, output wide_mode,
                   input ad_value);
  modport formatter (input cur_addr, input page, input wide_mode,
                     output ad_value);
endinterface : addr_phase_if
`default_nettype wire

// ===== rtl/ad_formatter.sv
// Purpose: Builds the AD word of a DMA address phase.
// Assumes: AD31-AD24 carry zero.
// Notes:   Pure combinational mapping.
`timescale 1ns/1ps
`default_nettype none
module ad_formatter (
  addr_phase_if.formatter ap  // Address state in, AD word out
);
  // ==========================================================
  // Lane mapping
  // ==========================================================
  always_comb
  begin
    if (ap.wide_mode)
      ap.ad_value = {8'h00, ap.page[7:1], ap.cur_addr, 1'b0};
    else
      ap.ad_value = {8'h00, ap.page, ap.cur_addr};
  end
endmodule : ad_formatter
`default_nettype wire

// ===== rtl/distributed_dma_channel.sv
// Purpose: Register window and address generation of a DMA slave channel.
// Assumes: PCI target logic presents decoded-phase strobes on clk.
// Notes:   Read data is registered one cycle after io_rd.
`timescale 1ns/1ps
`default_nettype none
module distributed_dma_channel (
  input  wire logic        clk,         // PCI clock, 25 MHz
  input  wire logic        rstn,        // Async reset, active low
  input  wire logic        cfg_wr,      // Config write strobe
  input  wire logic [7:0]  cfg_offset,  // Config dword offset
  input  wire logic [3:0]  cfg_be,      // Config byte enables
  input  wire logic [31:0] cfg_wdata,   // Config write data
  output logic      [31:0] cfg_rdata,   // Window base readback
  input  wire logic [31:0] io_addr,     // I/O address of access
  input  wire logic        io_rd,       // I/O read strobe
  input  wire logic        io_wr,       // I/O write strobe
  input  wire logic [3:0]  io_be,       // I/O byte enables
  input  wire logic [31:0] io_wdata,    // I/O write data
  output logic             io_hit,      // Address falls in window
  output logic      [31:0] io_rdata,    // Registered read data
  input  wire logic        dreq_pin,    // Card DMA request pin
  input  wire logic        wide_mode,   // 16-bit transfer mode
  input  wire logic        addr_phase,  // Bus cycle address phase
  input  wire logic        xfer_done,   // One transfer completed
  output logic      [31:0] ad_out,      // AD value to drive
  output logic             ad_oe,       // AD output enable
  output logic             chan_enable, // Channel may request
  output logic             tc_reached   // Terminal count seen
);
  // ==========================================================
  // State
  // ==========================================================
  logic [31:0] base_reg,  base_next;
  logic [15:0] baddr_reg, baddr_next;
  logic [15:0] caddr_reg, caddr_next;
  logic [15:0] bcnt_reg,  bcnt_next;
  logic [15:0] ccnt_reg,  ccnt_next;
  logic [7:0]  page_reg,  page_next;
  logic [7:0]  cmd_reg,   cmd_next;
  logic [7:0]  mode_reg,  mode_next;
  logic        mask_reg,  mask_next;
  logic        swreq_reg, swreq_next;
  logic        tc_reg,    tc_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [31:0] ad_reg;
  logic        oe_reg;
  logic        dreq_s1_reg, dreq_s2_reg;
  logic [3:0]  ofs;
  logic        wr_addr, wr_count, wr_stat, wr_multi;
  logic        rd_stat, clear_chan, do_xfer;
  logic [15:0] step;
  addr_phase_if ap ();

  assign ofs = io_addr[distributed_dma_pkg::WINDOW_BITS-1:0];
  assign io_hit = ((io_addr & distributed_dma_pkg::WINDOW_MASK)
                   == (base_reg & distributed_dma_pkg::WINDOW_MASK));
  assign wr_addr  = io_wr && io_hit && (ofs == distributed_dma_pkg::OFS_ADDR);
  assign wr_count = io_wr && io_hit && (ofs == distributed_dma_pkg::OFS_COUNT);
  assign wr_stat  = io_wr && io_hit && (ofs == distributed_dma_pkg::OFS_STATUS);
  assign wr_multi = io_wr && io_hit && (ofs == distributed_dma_pkg::OFS_MULTI);
  assign rd_stat  = io_rd && io_hit && (ofs == distributed_dma_pkg::OFS_STATUS)
                    && io_be[0];
  assign clear_chan = wr_multi && io_be[1];
  assign step = wide_mode ? distributed_dma_pkg::STEP_16BIT
                          : distributed_dma_pkg::STEP_8BIT;
  assign do_xfer = xfer_done && !cmd_reg[distributed_dma_pkg::CMD_DISABLE_BIT];

  // ==========================================================
  // Configuration base
  // ==========================================================
  always_comb
  begin
    base_next = base_reg;
    if (cfg_wr && (cfg_offset == distributed_dma_pkg::CFG_BASE_OFFSET))
    begin
      for (int i = 0; i < 4; i++)
        if (cfg_be[i])
          base_next[i*8 +: 8] = cfg_wdata[i*8 +: 8];
      base_next = (base_next & distributed_dma_pkg::WINDOW_MASK)
                  | distributed_dma_pkg::IO_SPACE_FLAG;
    end
  end
  assign cfg_rdata = base_reg;

  // ==========================================================
  // Channel registers
  // ==========================================================
  always_comb
  begin
    baddr_next = baddr_reg;
    caddr_next = caddr_reg;
    bcnt_next  = bcnt_reg;
    ccnt_next  = ccnt_reg;
    page_next  = page_reg;
    cmd_next   = cmd_reg;
    mode_next  = mode_reg;
    mask_next  = mask_reg;
    swreq_next = swreq_reg;
    tc_next    = tc_reg;
    if (do_xfer)
    begin
      caddr_next = 16'(caddr_reg + step);
      ccnt_next  = 16'(ccnt_reg - step);
    end
    if (wr_addr)
    begin
      if (io_be[0])
      begin
        baddr_next[7:0] = io_wdata[7:0];
        caddr_next[7:0] = io_wdata[7:0];
      end
      if (io_be[1])
      begin
        baddr_next[15:8] = io_wdata[15:8];
        caddr_next[15:8] = io_wdata[15:8];
      end
      if (io_be[2])
        page_next = io_wdata[23:16];
    end
    if (wr_count)
    begin
      if (io_be[0])
      begin
        bcnt_next[7:0] = io_wdata[7:0];
        ccnt_next[7:0] = io_wdata[7:0];
      end
      if (io_be[1])
      begin
        bcnt_next[15:8] = io_wdata[15:8];
        ccnt_next[15:8] = io_wdata[15:8];
      end
    end
    if (wr_stat)
    begin
      if (io_be[0])
      begin
        cmd_next = distributed_dma_pkg::BYTE_RESET;
        cmd_next[distributed_dma_pkg::CMD_DISABLE_BIT] =
          io_wdata[distributed_dma_pkg::CMD_DISABLE_BIT];
      end
      if (io_be[1])
        swreq_next = 1'b1;
      if (io_be[3])
        mode_next = io_wdata[31:24] & distributed_dma_pkg::MODE_WR_MASK;
    end
    if (wr_multi && io_be[3])
      mask_next = io_wdata[24 + distributed_dma_pkg::MASK_BIT];
    if (rd_stat || clear_chan)
      tc_next = 1'b0;
    if (clear_chan)
    begin
      cmd_next   = distributed_dma_pkg::BYTE_RESET;
      mode_next  = distributed_dma_pkg::BYTE_RESET;
      swreq_next = 1'b0;
      mask_next  = 1'b1;
    end
    if (do_xfer && (ccnt_reg < step))
      tc_next = 1'b1;
  end

  // ==========================================================
  // Read mux
  // ==========================================================
  always_comb
  begin
    rdata_next = rdata_reg;
    if (io_rd && io_hit)
    begin
      rdata_next = 32'h0000_0000;
      case (ofs)
        distributed_dma_pkg::OFS_ADDR:   rdata_next = {8'h00, page_reg, caddr_reg};
        distributed_dma_pkg::OFS_COUNT:  rdata_next = {16'h0000, ccnt_reg};
        distributed_dma_pkg::OFS_STATUS:
          rdata_next = {24'h00_0000, {4{dreq_s2_reg}}, {4{tc_reg}}};
        distributed_dma_pkg::OFS_MULTI:
          rdata_next = {4'h0, {4{mask_reg}}, 24'h00_0000};
        default:              rdata_next = 32'h0000_0000;
      endcase
    end
  end

  // ==========================================================
  // Address phase
  // ==========================================================
  assign ap.cur_addr  = caddr_reg;
  assign ap.page      = page_reg;
  assign ap.wide_mode = wide_mode;

  ad_formatter u_fmt (
    .ap (ap)
  );

  // ==========================================================
  // Registers
  // ==========================================================
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      base_reg    <= distributed_dma_pkg::IO_SPACE_FLAG;
      baddr_reg   <= distributed_dma_pkg::ADDR_RESET;
      caddr_reg   <= distributed_dma_pkg::ADDR_RESET;
      bcnt_reg    <= distributed_dma_pkg::COUNT_RESET;
      ccnt_reg    <= distributed_dma_pkg::COUNT_RESET;
      page_reg    <= distributed_dma_pkg::PAGE_RESET;
      cmd_reg     <= distributed_dma_pkg::BYTE_RESET;
      mode_reg    <= distributed_dma_pkg::BYTE_RESET;
      mask_reg    <= 1'b1;
      swreq_reg   <= 1'b0;
      tc_reg      <= 1'b0;
      rdata_reg   <= 32'h0000_0000;
      ad_reg      <= 32'h0000_0000;
      oe_reg      <= 1'b0;
      dreq_s1_reg <= 1'b0;
      dreq_s2_reg <= 1'b0;
    end
    else
    begin
      base_reg    <= base_next;
      baddr_reg   <= baddr_next;
      caddr_reg   <= caddr_next;
      bcnt_reg    <= bcnt_next;
      ccnt_reg    <= ccnt_next;
      page_reg    <= page_next;
      cmd_reg     <= cmd_next;
      mode_reg    <= mode_next;
      mask_reg    <= mask_next;
      swreq_reg   <= swreq_next;
      tc_reg      <= tc_next;
      rdata_reg   <= rdata_next;
      ad_reg      <= ap.ad_value;
      oe_reg      <= addr_phase;
      dreq_s1_reg <= dreq_pin;
      dreq_s2_reg <= dreq_s1_reg;
    end
  end

  assign io_rdata    = rdata_reg;
  assign ad_out      = ad_reg;
  assign ad_oe       = oe_reg;
  assign tc_reached  = tc_reg;
  assign chan_enable = !cmd_reg[distributed_dma_pkg::CMD_DISABLE_BIT] && !mask_reg
                       && (dreq_s2_reg || swreq_reg);
endmodule : distributed_dma_channel
`default_nettype wire

// ===== tb/channel_properties.sv
// Purpose: Port-level timing checks for the slave channel.
// Assumes: One clock domain, asynchronous active-low reset.
// Notes:   Bound into every distributed_dma_channel instance.
`timescale 1ns/1ps
`default_nettype none
module channel_port_checker (
  input wire logic        clk,        // Bus clock
  input wire logic        rstn,       // Reset, active low
  input wire logic [31:0] cfg_rdata,  // Window base readback
  input wire logic [31:0] io_addr,    // Access address
  input wire logic        io_rd,      // Read strobe
  input wire logic [3:0]  io_be,      // Byte lanes
  input wire logic        io_hit,     // Window hit
  input wire logic [31:0] io_rdata,   // Read data
  input wire logic        wide_mode,  // 16-bit mode
  input wire logic        addr_phase, // Address phase
  input wire logic        xfer_done,  // Transfer done
  input wire logic [31:0] ad_out,     // AD word
  input wire logic        ad_oe,      // AD enable
  input wire logic        tc_reached  // Terminal count
);
  // ============================================================
  // Properties
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  wire rd_hit = io_rd && io_hit;
  property p_hit; io_hit == (io_addr[31:4] == cfg_rdata[31:4]); endproperty
  property p_oe; addr_phase |=> ad_oe && ad_out[31:24] == 8'h00; endproperty
  property p_wide; addr_phase && wide_mode |=> !ad_out[0]; endproperty
  property p_tcset; $rose(tc_reached) |-> $past(xfer_done); endproperty
  property p_tcclr;
    rd_hit && io_addr[3:0] == 4'h8 && io_be[0] && !xfer_done |=> !tc_reached;
  endproperty
  property p_rsv;
    rd_hit && io_addr[3:0] == 4'h4 |=> io_rdata[31:16] == 16'h0000;
  endproperty
  property p_obs;
    rd_hit && io_addr[3:0] == 4'h8 |=> io_rdata[31:8] == 24'h00_0000;
  endproperty
  property p_hold; !rd_hit |=> $stable(io_rdata); endproperty
  a_hit: assert property (p_hit) else $error("window hit wrong");
  a_oe: assert property (p_oe) else $error("address phase wrong");
  a_wide: assert property (p_wide) else $error("AD0 not low");
  a_tcset: assert property (p_tcset) else $error("tc rose alone");
  a_tcclr: assert property (p_tcclr) else $error("tc not cleared");
  a_rsv: assert property (p_rsv) else $error("reserved lanes set");
  a_obs: assert property (p_obs) else $error("status upper set");
  a_hold: assert property (p_hold) else $error("read data moved");
  c_wide: cover property (addr_phase && wide_mode);
  c_tc: cover property ($rose(tc_reached));
  c_multi: cover property (rd_hit && io_addr[3:0] == 4'hC);
endmodule : channel_port_checker
bind distributed_dma_channel channel_port_checker chk (.clk, .rstn, .cfg_rdata,
  .io_addr, .io_rd, .io_be, .io_hit, .io_rdata, .wide_mode, .addr_phase,
  .xfer_done, .ad_out, .ad_oe, .tc_reached);
`default_nettype wire

// ===== tb/pci_host_model.sv
// Purpose: Bus host and master DMA device facing the channel.
// Assumes: Signals change just after rising edges.
// Notes:   Idle data lines carry inverted data.
`timescale 1ns/1ps
`default_nettype none
module pci_host_model (
  input  wire logic        clk,        // Bus clock
  input  wire logic [31:0] io_rdata,   // Read data
  output var  logic        cfg_wr,     // Config write
  output var  logic [7:0]  cfg_offset, // Config offset
  output var  logic [3:0]  cfg_be,     // Config lanes
  output var  logic [31:0] cfg_wdata,  // Config data
  output var  logic [31:0] io_addr,    // I/O address
  output var  logic        io_rd,      // I/O read
  output var  logic        io_wr,      // I/O write
  output var  logic [3:0]  io_be,      // I/O lanes
  output var  logic [31:0] io_wdata,   // I/O data
  output var  logic        addr_phase, // Address phase
  output var  logic        xfer_done   // Transfer done
);
  initial {cfg_wr, io_rd, io_wr, addr_phase, xfer_done} = '0;
  initial {cfg_offset, cfg_be, cfg_wdata, io_addr, io_be, io_wdata} = '0;
  // ============================================================
  // Bus cycles
  task automatic cfg_write(input logic [7:0] o, input logic [3:0] be,
    input logic [31:0] d);
    @(posedge clk);
    cfg_wr <= 1'b1;
    cfg_offset <= o;
    cfg_be <= be;
    cfg_wdata <= d;
    @(posedge clk);
    cfg_wr <= 1'b0;
    cfg_wdata <= ~d;
    #1;
  endtask : cfg_write
  task automatic access(input logic wr, input logic [31:0] a,
    input logic [3:0] be, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk);
    io_rd <= !wr;
    io_wr <= wr;
    io_addr <= a;
    io_be <= be;
    io_wdata <= d;
    @(posedge clk);
    io_rd <= 1'b0;
    io_wr <= 1'b0;
    io_wdata <= ~d;
    #1 q = io_rdata;
  endtask : access
  task automatic strobe(input logic ap);
    @(posedge clk);
    addr_phase <= ap;
    xfer_done <= !ap;
    @(posedge clk);
    addr_phase <= 1'b0;
    xfer_done <= 1'b0;
    #1;
  endtask : strobe
endmodule : pci_host_model
`default_nettype wire

// ===== tb/test_distributed_dma_slave_addressing.sv
// Purpose: Self-checking bench for the slave channel.
// Assumes: Window base placed at 1000h.
// Notes:   Host model drives all bus cycles.
`timescale 1ns/1ps
`default_nettype none
module test_distributed_dma_slave_addressing;
  logic clk, rstn, dreq_pin, wide_mode, cfg_wr, io_rd, io_wr, io_hit;
  logic addr_phase, xfer_done, ad_oe, chan_enable, tc_reached;
  logic [31:0] cfg_rdata, io_rdata, ad_out, io_addr, cfg_wdata, io_wdata, q;
  logic [7:0] cfg_offset;
  logic [3:0] cfg_be, io_be;
  int err_count = 0, n_checks = 0, cycles = 0;
  distributed_dma_channel dut (.clk, .rstn, .cfg_wr, .cfg_offset, .cfg_be, .cfg_wdata,
    .cfg_rdata, .io_addr, .io_rd, .io_wr, .io_be, .io_wdata, .io_hit,
    .io_rdata, .dreq_pin, .wide_mode, .addr_phase, .xfer_done, .ad_out,
    .ad_oe, .chan_enable, .tc_reached);
  pci_host_model h (.clk, .io_rdata, .cfg_wr, .cfg_offset, .cfg_be,
    .cfg_wdata, .io_addr, .io_rd, .io_wr, .io_be, .io_wdata, .addr_phase,
    .xfer_done);
  // ============================================================
  // Checking and closing
  task automatic check(input string n, input logic [31:0] e, g);
    n_checks++;
    if (g !== e)
    begin
      err_count++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask : check
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : complete_run
  // ============================================================
  // Scenarios
  task automatic t_window();
    check("base", 32'h0000_0001, cfg_rdata);
    h.access(1'b0, 32'h0000_0000, 4'hF, 32'h0, q);
    check("page reset", 32'h0000_0000, q);
    h.cfg_write(8'h98, 4'hF, 32'h0000_1000);
    check("base", 32'h0000_1001, cfg_rdata);
    h.cfg_write(8'h9C, 4'hF, 32'h0000_3000);
    check("base", 32'h0000_1001, cfg_rdata);
    h.cfg_write(8'h98, 4'h4, 32'hFFFF_FFFF);
    check("base", 32'h00FF_1001, cfg_rdata);
    h.cfg_write(8'h98, 4'h4, 32'h0000_0000);
    h.access(1'b1, 32'h0000_2000, 4'h7, 32'h00FF_FFFF, q);
    h.access(1'b0, 32'h0000_2004, 4'hF, 32'h0, q);
    check("miss", 32'h0000_0000, q);
    h.access(1'b0, 32'h0000_1000, 4'hF, 32'h0, q);
    check("miss write", 32'h0000_0000, q);
  endtask : t_window
  task automatic t_address();
    h.access(1'b1, 32'h0000_1000, 4'h7, 32'h00AB_1234, q);
    h.access(1'b0, 32'h0000_1000, 4'hF, 32'h0, q);
    check("address", 32'h00AB_1234, q);
    h.strobe(1'b1);
    check("ad 8", 32'h00AB_1234, ad_out);
    @(posedge clk) wide_mode <= 1'b1;
    h.strobe(1'b1);
    check("ad 16", 32'h00AA_2468, ad_out);
    check("oe", 32'h1, {31'h0, ad_oe});
  endtask : t_address
  task automatic t_count();
    @(posedge clk) wide_mode <= 1'b0;
    h.access(1'b1, 32'h0000_1004, 4'h3, 32'h0000_0003, q);
    h.strobe(1'b0);
    h.strobe(1'b0);
    @(posedge clk) wide_mode <= 1'b1;
    h.strobe(1'b0);
    check("tc", 32'h1, {31'h0, tc_reached});
    h.access(1'b0, 32'h0000_1000, 4'hF, 32'h0, q);
    check("address", 32'h00AB_1238, q);
    h.access(1'b0, 32'h0000_1004, 4'hF, 32'h0, q);
    check("count", 32'h0000_FFFF, q);
    h.access(1'b0, 32'h0000_1008, 4'h1, 32'h0, q);
    check("status", 32'h0000_000F, q);
    h.access(1'b0, 32'h0000_1008, 4'h1, 32'h0, q);
    check("status", 32'h0000_0000, q);
  endtask : t_count
  task automatic t_reserved();
    h.access(1'b1, 32'h0000_1004, 4'hC, 32'hFFFF_0000, q);
    h.access(1'b0, 32'h0000_1004, 4'hF, 32'h0, q);
    check("count", 32'h0000_FFFF, q);
    h.access(1'b0, 32'h0000_1006, 4'hF, 32'h0, q);
    check("reserved", 32'h0000_0000, q);
    h.access(1'b0, 32'h0000_100C, 4'hF, 32'h0, q);
    check("mask", 32'h0F00_0000, q);
    h.access(1'b1, 32'h0000_1008, 4'h1, 32'h0000_0004, q);
    h.strobe(1'b0);
    h.access(1'b0, 32'h0000_1000, 4'hF, 32'h0, q);
    check("halted", 32'h00AB_1238, q);
    h.access(1'b1, 32'h0000_1008, 4'h1, 32'h0000_0000, q);
  endtask : t_reserved
  task automatic t_request();
    h.access(1'b1, 32'h0000_100C, 4'h8, 32'h0000_0000, q);
    @(posedge clk) dreq_pin <= 1'b1;
    repeat (4) @(posedge clk);
    #1 check("enable", 32'h1, {31'h0, chan_enable});
    h.access(1'b0, 32'h0000_1008, 4'h1, 32'h0, q);
    check("status", 32'h0000_00F0, q);
    h.access(1'b1, 32'h0000_100C, 4'h2, 32'h0, q);
    repeat (2) @(posedge clk);
    #1 check("cleared", 32'h0, {31'h0, chan_enable});
    @(posedge clk) dreq_pin <= 1'b0;
    h.access(1'b1, 32'h0000_100C, 4'h8, 32'h0000_0000, q);
    h.access(1'b1, 32'h0000_1008, 4'hA, 32'hFF00_0000, q);
    check("sw request", 32'h1, {31'h0, chan_enable});
    h.access(1'b0, 32'h0000_1008, 4'h1, 32'h0, q);
    check("status", 32'h0000_0000, q);
  endtask : t_request
  task automatic t_reset();
    h.access(1'b1, 32'h0000_1004, 4'h3, 32'h0000_0000, q);
    h.strobe(1'b0);
    check("tc", 32'h1, {31'h0, tc_reached});
    @(posedge clk) rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    #1 check("tc", 32'h0, {31'h0, tc_reached});
    check("base", 32'h0000_0001, cfg_rdata);
    h.access(1'b0, 32'h0000_0000, 4'hF, 32'h0, q);
    check("page reset", 32'h0000_0000, q);
  endtask : t_reset
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 3000)
    begin
      err_count++;
      complete_run();
    end
  end
  initial
  begin
    rstn = 1'b0;
    dreq_pin = 1'b0;
    wide_mode = 1'b0;
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    t_window();
    t_address();
    t_count();
    t_reserved();
    t_request();
    t_reset();
    complete_run();
  end
endmodule : test_distributed_dma_slave_addressing
`default_nettype wire
